/* File: rtl/pbs_pkg.sv */
// pbs_pkg: constants and types for the push-button power sequencer
// assumes a 100 MHz mclk_i and one shared 1 ms time-base tick
package pbs_pkg;

  // ==========================================================
  // clock and time base
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_NS       = 1_000_000;                 // one time-base tick is 1 ms
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000;             // cycles per 1 ms tick
  localparam int unsigned HALT_MIN_NS   = 30_000;                    // 30 us halt filter
  localparam int unsigned HALT_CYCLES   = (HALT_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ==========================================================
  // interval lengths in ms ticks
  localparam int unsigned DEBOUNCE_MS   = 32;
  localparam int unsigned EXTRA_BASE_MS = 1;
  localparam int unsigned BLANK_MS      = 512;
  localparam int unsigned LOCKOUT_MS    = 256;
  localparam int unsigned FORCE_OFF_MS  = 1024;

  // ==========================================================
  // widths
  localparam int unsigned MS_W          = 12;
  localparam int unsigned EXTRA_W       = 10;

  // ==========================================================
  // sequencer states, gray along off -> press -> on -> alert path
  typedef enum logic [2:0] {
    PBS_IDLE     = 3'h0,
    PBS_ON_DEB   = 3'h1,
    PBS_BLANK    = 3'h3,
    PBS_REL_DEB  = 3'h2,
    PBS_RUN      = 3'h6,
    PBS_OFF_DEB  = 3'h7,
    PBS_ALERT    = 3'h5,
    PBS_LOCKOUT  = 3'h4
  } pbs_state_t;

  // ==========================================================
  // outward signals carried together
  typedef struct packed {
    logic supply_en;       // logical enable, before polarity
    logic shutdown_alert;  // logical alert, active when high
  } pbs_out_t;

endpackage

/* File: rtl/pbs_sequencer.sv */
// pbs_sequencer: push-button power on/off sequencer core
// assumes button_n_i and halt_n_i are asynchronous pins; one clock, synchronous reset
//
// What this block does
// - at blanking end, a still-low halt request drops supply enable
// - in normal running, a filtered halt low drops supply enable at once
// - after a halt-caused release, except one at blanking end, ignore the button for 256 ms
// - build parameter picks supply-enable polarity; nothing else differs
// - with no extension, button low 32 ms before a press counts
// - on and off extensions each add 1 ms plus their setting
// - after a valid off press, release supply within 1024 ms regardless
// - halt lows shorter than 30 us are ignored
// - after enabling supply, ignore halt and button for 512 ms
// - completed off press drives the shutdown alert low
// - button going high during debounce restarts the debounce timer
// - release of the button is debounced 32 ms after blank and turn-off
`timescale 1ns/1ns
module pbs_sequencer #(
  parameter bit          EN_ACTIVE_HIGH = 1'b1,                      // polarity build option
  parameter int unsigned TICK_CYCLES    = pbs_pkg::TICK_CYCLES      // shorten for simulation
) (
  // clock and reset
  input  wire logic                         mclk_i,
  input  wire logic                         reset_i,
  // pins from the button and host
  input  wire logic                         button_n_i,
  input  wire logic                         halt_n_i,
  // extension settings in ms, zero means none
  input  wire logic [pbs_pkg::EXTRA_W-1:0]  turn_on_delay_extra_i,
  input  wire logic [pbs_pkg::EXTRA_W-1:0]  turn_off_delay_extra_i,
  // outputs to supply and host
  output logic                              supply_en_o,
  output logic                              shutdown_alert_n_o
);

  // ==========================================================
  // input synchronisers
  logic [2:0] btn_sync_ff;
  logic [2:0] halt_sync_ff;
  logic       btn_low_ff;
  logic       halt_raw_low_ff;

  // three stages; only stages two and three are compared
  always_ff @(posedge mclk_i) begin
    btn_sync_ff  <= {btn_sync_ff[1:0], button_n_i};
    halt_sync_ff <= {halt_sync_ff[1:0], halt_n_i};
  end

  wire btn_agree  = btn_sync_ff[1] == btn_sync_ff[2];
  wire halt_agree = halt_sync_ff[1] == halt_sync_ff[2];

  // a level change counts once stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      btn_low_ff      <= 1'b0;
      halt_raw_low_ff <= 1'b0;
    end else begin
      if (btn_agree)  btn_low_ff      <= ~btn_sync_ff[2];
      if (halt_agree) halt_raw_low_ff <= ~halt_sync_ff[2];
    end
  end

  // ==========================================================
  // halt pulse filter: low must hold 30 us before it is seen
  localparam int unsigned HF_W = $clog2(pbs_pkg::HALT_CYCLES + 1);
  logic [HF_W-1:0] halt_cnt_ff;
  logic            halt_low_ff;

  wire halt_cnt_done = halt_cnt_ff == HF_W'(pbs_pkg::HALT_CYCLES - 1);

  // any high restarts the count, so short glitches never reach the fsm
  always_ff @(posedge mclk_i) begin
    if (reset_i || !halt_raw_low_ff) begin
      halt_cnt_ff <= '0;
      halt_low_ff <= 1'b0;
    end else if (halt_cnt_done) begin
      halt_low_ff <= 1'b1;
    end else begin
      halt_cnt_ff <= halt_cnt_ff + HF_W'(1);
    end
  end

  // ==========================================================
  // common 1 ms time base
  localparam int unsigned TB_W = $clog2(TICK_CYCLES + 1);
  logic [TB_W-1:0] tb_cnt_ff;
  logic            tick_ff;

  // single tick pulse feeds every interval timer
  always_ff @(posedge mclk_i) begin
    if (reset_i || tb_cnt_ff == TB_W'(TICK_CYCLES - 1)) begin
      tb_cnt_ff <= '0;
      tick_ff   <= ~reset_i;
    end else begin
      tb_cnt_ff <= tb_cnt_ff + TB_W'(1);
      tick_ff   <= 1'b0;
    end
  end

  // ==========================================================
  // state machine
  pbs_pkg::pbs_state_t             state_ff;
  pbs_pkg::pbs_state_t             nxt_state;
  logic [pbs_pkg::MS_W-1:0]        ms_ff;
  logic [pbs_pkg::MS_W-1:0]        nxt_ms;
  logic                            after_on_ff;      // release debounce leads to run, not idle
  logic                            nxt_after_on;
  pbs_pkg::pbs_out_t               out_ff;
  pbs_pkg::pbs_out_t               nxt_out;

  // required press lengths; extension adds 1 ms plus setting
  wire [pbs_pkg::MS_W-1:0] on_need  = (turn_on_delay_extra_i == '0) ? pbs_pkg::MS_W'(pbs_pkg::DEBOUNCE_MS) :
    pbs_pkg::MS_W'(pbs_pkg::DEBOUNCE_MS + pbs_pkg::EXTRA_BASE_MS) + pbs_pkg::MS_W'(turn_on_delay_extra_i);
  wire [pbs_pkg::MS_W-1:0] off_need = (turn_off_delay_extra_i == '0) ? pbs_pkg::MS_W'(pbs_pkg::DEBOUNCE_MS) :
    pbs_pkg::MS_W'(pbs_pkg::DEBOUNCE_MS + pbs_pkg::EXTRA_BASE_MS) + pbs_pkg::MS_W'(turn_off_delay_extra_i);
  wire [pbs_pkg::MS_W-1:0] ms_inc   = ms_ff + pbs_pkg::MS_W'(1);

  // ms_ff counts elapsed ticks in the current state; each entry clears it
  always_comb begin
    nxt_state    = state_ff;
    nxt_ms       = tick_ff ? ms_inc : ms_ff;
    nxt_after_on = after_on_ff;
    nxt_out      = out_ff;
    unique case (state_ff)
      pbs_pkg::PBS_IDLE: begin
        nxt_ms = '0;
        if (btn_low_ff) nxt_state = pbs_pkg::PBS_ON_DEB;
      end
      pbs_pkg::PBS_ON_DEB: begin
        if (!btn_low_ff) begin
          nxt_state = pbs_pkg::PBS_IDLE;
        end else if (tick_ff && ms_inc >= on_need) begin
          nxt_state   = pbs_pkg::PBS_BLANK;
          nxt_ms      = '0;
          nxt_out.supply_en = 1'b1;
        end
      end
      pbs_pkg::PBS_BLANK: begin
        // button not looked at here; halt checked only at blanking end
        if (tick_ff && ms_inc == pbs_pkg::MS_W'(pbs_pkg::BLANK_MS)) begin
          nxt_ms = '0;
          if (halt_low_ff) begin
            nxt_out.supply_en = 1'b0;
            nxt_state         = pbs_pkg::PBS_REL_DEB;
            nxt_after_on      = 1'b0;
          end else begin
            nxt_state    = pbs_pkg::PBS_REL_DEB;
            nxt_after_on = 1'b1;
          end
        end
      end
      pbs_pkg::PBS_REL_DEB: begin
        // button must sit high for 32 ms before the next press is watched
        if (btn_low_ff) begin
          nxt_ms = '0;
        end else if (tick_ff && ms_inc == pbs_pkg::MS_W'(pbs_pkg::DEBOUNCE_MS)) begin
          nxt_ms    = '0;
          nxt_state = after_on_ff ? pbs_pkg::PBS_RUN : pbs_pkg::PBS_IDLE;
        end
        if (after_on_ff && halt_low_ff) begin
          nxt_out.supply_en = 1'b0;
          nxt_state         = pbs_pkg::PBS_LOCKOUT;
          nxt_ms            = '0;
        end
      end
      pbs_pkg::PBS_RUN: begin
        nxt_ms = '0;
        if (halt_low_ff) begin
          nxt_out.supply_en = 1'b0;
          nxt_state         = pbs_pkg::PBS_LOCKOUT;
        end else if (btn_low_ff) begin
          nxt_state = pbs_pkg::PBS_OFF_DEB;
        end
      end
      pbs_pkg::PBS_OFF_DEB: begin
        if (halt_low_ff) begin
          nxt_out.supply_en = 1'b0;
          nxt_state         = pbs_pkg::PBS_LOCKOUT;
          nxt_ms            = '0;
        end else if (!btn_low_ff) begin
          nxt_state = pbs_pkg::PBS_RUN;
        end else if (tick_ff && ms_inc >= off_need) begin
          nxt_state              = pbs_pkg::PBS_ALERT;
          nxt_ms                 = '0;
          nxt_out.shutdown_alert = 1'b1;
        end
      end
      pbs_pkg::PBS_ALERT: begin
        // host normally halts first; the timer is the backstop
        if (halt_low_ff) begin
          nxt_out           = '0;
          nxt_state         = pbs_pkg::PBS_LOCKOUT;
          nxt_ms            = '0;
        end else if (tick_ff && ms_inc == pbs_pkg::MS_W'(pbs_pkg::FORCE_OFF_MS)) begin
          nxt_out      = '0;
          nxt_state    = pbs_pkg::PBS_REL_DEB;
          nxt_after_on = 1'b0;
          nxt_ms       = '0;
        end
      end
      pbs_pkg::PBS_LOCKOUT: begin
        // button ignored while the supply output decays
        nxt_out.shutdown_alert = 1'b0;
        if (tick_ff && ms_inc == pbs_pkg::MS_W'(pbs_pkg::LOCKOUT_MS)) begin
          nxt_state    = pbs_pkg::PBS_REL_DEB;
          nxt_after_on = 1'b0;
          nxt_ms       = '0;
        end
      end
    endcase
  end

  // state registers; reset holds supply off
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_ff    <= pbs_pkg::PBS_IDLE;
      ms_ff       <= '0;
      after_on_ff <= 1'b0;
      out_ff      <= '0;
    end else begin
      state_ff    <= nxt_state;
      ms_ff       <= nxt_ms;
      after_on_ff <= nxt_after_on;
      out_ff      <= nxt_out;
    end
  end

  // ==========================================================
  // pin polarity; only the enable inverts with the build option
  assign supply_en_o        = EN_ACTIVE_HIGH ? out_ff.supply_en : ~out_ff.supply_en;
  assign shutdown_alert_n_o = ~out_ff.shutdown_alert;

endmodule

/* File: test/pbs_host_model.sv */
// host model: boots after supply on, answers the alert with a halt
// assumes supply_on_i is the logical enable of the sequencer
`timescale 1ns/1ns
module pbs_host_model #(
  parameter int unsigned BOOT = 200,
  parameter int unsigned HK   = 100
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // from the sequencer and the bench
  input  wire logic supply_on_i,
  input  wire logic shutdown_alert_n_i,
  input  wire logic boot_en_i,
  input  wire logic ack_en_i,
  input  wire logic drop_n_i,
  // halt request
  output logic      halt_n_o
);
  int unsigned up_cnt;
  int unsigned hk_cnt;
  // boot and housekeeping timers, held at their limit
  always_ff @(posedge mclk_i) begin
    up_cnt <= (reset_i || !supply_on_i) ? 0 : (up_cnt < BOOT ? up_cnt + 1 : up_cnt);
    hk_cnt <= (reset_i || shutdown_alert_n_i) ? 0 : (hk_cnt < HK ? hk_cnt + 1 : hk_cnt);
  end
  // unpowered host holds halt low; a booted one raises it inside blanking
  assign halt_n_o = boot_en_i && up_cnt >= BOOT && !(ack_en_i && hk_cnt >= HK) && drop_n_i;
endmodule

/* File: test/pbs_sequencer_properties.sv */
// checker: timing relations seen at the sequencer ports
// assumes a bind onto every pbs_sequencer instance
`timescale 1ns/1ns
module pbs_sequencer_properties #(
  parameter bit          EN_ACTIVE_HIGH = 1'b1,
  parameter int unsigned TICK_CYCLES    = 100
) (
  // clock and reset
  input wire logic                        mclk_i,
  input wire logic                        reset_i,
  // inputs of the sequencer
  input wire logic                        button_n_i,
  input wire logic                        halt_n_i,
  input wire logic [pbs_pkg::EXTRA_W-1:0] turn_on_delay_extra_i,
  input wire logic [pbs_pkg::EXTRA_W-1:0] turn_off_delay_extra_i,
  // outputs of the sequencer
  input wire logic                        supply_en_o,
  input wire logic                        shutdown_alert_n_o
);
  // ==========================================
  // helpers
  wire         sup_on = (supply_en_o == EN_ACTIVE_HIGH);
  int unsigned b_cnt;
  int unsigned on_cnt;
  int unsigned al_cnt;
  int unsigned h_cnt;
  logic        b_prev;
  function automatic int unsigned need(input logic [pbs_pkg::EXTRA_W-1:0] e);
    return (e == '0) ? 32 : 33 + e;
  endfunction
  // run lengths of each level; sync delay only lengthens them
  always_ff @(posedge mclk_i) begin
    b_prev <= button_n_i;
    b_cnt  <= (reset_i || (button_n_i && b_prev)) ? 0 : b_cnt + 1; // one-cycle bounce never reaches the fsm
    on_cnt <= (reset_i || !sup_on) ? 0 : on_cnt + 1;
    al_cnt <= (reset_i || shutdown_alert_n_o) ? 0 : al_cnt + 1;
    h_cnt  <= (reset_i || halt_n_i) ? 0 : h_cnt + 1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ==========================================
  // assertions
  chk_reset_off: assert property ($fell(reset_i) |-> !sup_on && shutdown_alert_n_o)
    else $error("outputs active after reset");
  chk_on_press: assert property ($rose(sup_on) |-> b_cnt >= (need(turn_on_delay_extra_i) - 1) * TICK_CYCLES)
    else $error("supply on after short press");
  chk_off_press: assert property ($fell(shutdown_alert_n_o) |-> b_cnt >= (need(turn_off_delay_extra_i) - 1) * TICK_CYCLES)
    else $error("alert after short press");
  chk_blank_hold: assert property ($fell(sup_on) |-> on_cnt >= 511 * TICK_CYCLES)
    else $error("supply dropped inside blanking");
  chk_alert_on: assert property (!shutdown_alert_n_o |-> sup_on)
    else $error("alert without supply");
  chk_force_off: assert property (al_cnt <= 1026 * TICK_CYCLES)
    else $error("forced turn-off late");
  chk_halt_filter: assert property ($fell(sup_on) && !$past(shutdown_alert_n_o)
    |-> h_cnt >= 2990 || al_cnt >= 1020 * TICK_CYCLES)
    else $error("short halt pulse accepted");
  chk_halt_drop: assert property (!shutdown_alert_n_o && h_cnt == 2990 |-> ##[0:25] (!sup_on || halt_n_i))
    else $error("halt did not drop supply");
  chk_alert_clear: assert property ($fell(sup_on) |-> ##[0:1] shutdown_alert_n_o)
    else $error("alert left low after turn-off");
endmodule
bind pbs_sequencer pbs_sequencer_properties #(.EN_ACTIVE_HIGH(EN_ACTIVE_HIGH), .TICK_CYCLES(TICK_CYCLES))
  u_pbs_sequencer_properties (.mclk_i(mclk_i), .reset_i(reset_i), .button_n_i(button_n_i), .halt_n_i(halt_n_i),
  .turn_on_delay_extra_i(turn_on_delay_extra_i), .turn_off_delay_extra_i(turn_off_delay_extra_i),
  .supply_en_o(supply_en_o), .shutdown_alert_n_o(shutdown_alert_n_o));

/* File: test/test_pbs_sequencer.sv */
// testbench: presses, halts and turn-offs on both polarity builds
// assumes the host model and the bound checker
`timescale 1ns/1ns
module test_pbs_sequencer;
  localparam int TK = 16;
  logic                        mclk_i   = 1'b0;
  logic                        reset_i  = 1'b1;
  logic                        button_n = 1'b1;
  logic                        boot_en  = 1'b0;
  logic                        ack_en   = 1'b0;
  logic                        drop_n   = 1'b1;
  logic [pbs_pkg::EXTRA_W-1:0] ton      = '0;
  logic [pbs_pkg::EXTRA_W-1:0] toff     = '0;
  logic                        halt_n;
  logic                        sup;
  logic                        sup_lo;
  logic                        al_n;
  logic                        al_lo;
  int                          fails      = 0;
  int                          n_compared = 0;
  // ==========================================
  // clock, design and partner
  initial forever #5 mclk_i = ~mclk_i;
  pbs_sequencer #(.EN_ACTIVE_HIGH(1'b1), .TICK_CYCLES(TK)) u_pbs_sequencer (.mclk_i(mclk_i), .reset_i(reset_i),
    .button_n_i(button_n), .halt_n_i(halt_n), .turn_on_delay_extra_i(ton), .turn_off_delay_extra_i(toff),
    .supply_en_o(sup), .shutdown_alert_n_o(al_n));
  // second build with the inverted enable sees the same stimulus
  pbs_sequencer #(.EN_ACTIVE_HIGH(1'b0), .TICK_CYCLES(TK)) u_pbs_sequencer_2 (.mclk_i(mclk_i), .reset_i(reset_i),
    .button_n_i(button_n), .halt_n_i(halt_n), .turn_on_delay_extra_i(ton), .turn_off_delay_extra_i(toff),
    .supply_en_o(sup_lo), .shutdown_alert_n_o(al_lo));
  pbs_host_model u_pbs_host_model (.mclk_i(mclk_i), .reset_i(reset_i), .supply_on_i(sup),
    .shutdown_alert_n_i(al_n), .boot_en_i(boot_en), .ack_en_i(ack_en), .drop_n_i(drop_n), .halt_n_o(halt_n));
  // ==========================================
  // shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic compare(input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // sample just past the edge so the outputs have settled
  task automatic chk(input logic on, input logic aln);
    #1;
    compare({2'h0, sup, al_n}, {2'h0, on, aln});
    compare({2'h0, sup_lo, al_lo}, {2'h0, ~on, aln});
    @(posedge mclk_i);
  endtask
  task automatic power_up;
    button_n <= 1'b0;
    cyc(34 * TK);
    button_n <= 1'b1;
    cyc(560 * TK);
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_abort;
    button_n <= 1'b0;
    cyc(20 * TK);
    button_n <= 1'b1;
    cyc(2 * TK);
    button_n <= 1'b0;
    cyc(10 * TK);
    // a one-cycle bounce is filtered by the synchroniser and must not restart the timer
    button_n <= 1'b1;
    cyc(1);
    button_n <= 1'b0;
    cyc(20 * TK - 1);
    chk(1'b0, 1'b1);
    cyc(4 * TK);
    chk(1'b1, 1'b1);
    button_n <= 1'b1;
    cyc(500 * TK);
    chk(1'b1, 1'b1);
    cyc(20 * TK);
    chk(1'b0, 1'b1);
    cyc(40 * TK);
    $display("test abort done");
  endtask
  task automatic t_run;
    boot_en  <= 1'b1;
    ton      <= 10'h003;
    button_n <= 1'b0;
    cyc(34 * TK);
    chk(1'b0, 1'b1);
    cyc(4 * TK);
    chk(1'b1, 1'b1);
    button_n <= 1'b1;
    cyc(560 * TK);
    drop_n <= 1'b0;
    cyc(2000);
    drop_n <= 1'b1;
    cyc(20);
    chk(1'b1, 1'b1);
    drop_n <= 1'b0;
    cyc(3020);
    chk(1'b0, 1'b1);
    drop_n   <= 1'b1;
    button_n <= 1'b0;
    cyc(40 * TK);
    button_n <= 1'b1;
    chk(1'b0, 1'b1);
    cyc(300 * TK);
    $display("test halt done");
  endtask
  task automatic t_force;
    ton <= '0;
    power_up();
    button_n <= 1'b0;
    cyc(30 * TK);
    chk(1'b1, 1'b1);
    cyc(4 * TK);
    chk(1'b1, 1'b0);
    button_n <= 1'b1;
    cyc(1010 * TK);
    chk(1'b1, 1'b0);
    cyc(20 * TK);
    chk(1'b0, 1'b1);
    cyc(40 * TK);
    $display("test forced off done");
  endtask
  task automatic t_ack;
    toff   <= 10'h005;
    ack_en <= 1'b1;
    // press held past blanking: the release debounce keeps it from acting as an off press
    button_n <= 1'b0;
    cyc(600 * TK);
    chk(1'b1, 1'b1);
    button_n <= 1'b1;
    cyc(40 * TK);
    button_n <= 1'b0;
    cyc(36 * TK);
    chk(1'b1, 1'b1);
    cyc(4 * TK);
    chk(1'b1, 1'b0);
    button_n <= 1'b1;
    cyc(3300);
    chk(1'b0, 1'b1);
    cyc(40 * TK);
    $display("test host off done");
  endtask
  // ==========================================
  // main sequence and hang guard
  initial begin
    cyc(10);
    reset_i <= 1'b0;
    chk(1'b0, 1'b1);
    t_abort();
    t_run();
    t_force();
    t_ack();
    end_sim();
  end
  initial begin
    cyc(95000);
    fails++;
    end_sim();
  end
endmodule
